// ===== csc_pkg.sv
// Package for the configuration status and chaining handshake block
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package csc_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    CSC_IDLE,
    CSC_LOAD,
    CSC_INIT,
    CSC_USER,
    CSC_ERROR
  } csc_state_e;

  // Synchronised pin inputs, travelling together
  typedef struct packed {
    logic complete_line;
    logic status_line;
    logic chain_en_n;
    logic reconfig_n;
  } csc_pins_s;

  // Pad outputs toward the chain and the serial memory
  typedef struct packed {
    logic complete_oe;
    logic status_oe;
    logic chain_out_n;
    logic serial_mem_command_out;
    logic serial_mem_sel_n;
  } csc_pads_s;

  // Init-phase clocks counted with the completion line high, before user mode
  localparam int unsigned CSC_INIT_CYCLES = 8;
  localparam int unsigned CSC_CNT_W       = 8;
  // Serial memory read command opcode, shifted out msb first
  localparam logic [7:0]  CSC_READ_OPCODE = 8'h03;
  localparam logic [2:0]  CSC_BIT_LAST    = 3'h7;
  localparam logic [1:0]  CSC_SYNC_RESET  = 2'h3;

endpackage // csc_pkg

// ===== csc_handshake.sv
// Configuration status, chain enable and serial-memory control handshake
module csc_handshake #(
  parameter int unsigned INIT_CYCLES = csc_pkg::CSC_INIT_CYCLES
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic active_serial_mode,
  input  wire logic data_word_valid,
  input  wire logic data_last,
  input  wire logic data_error,
  input  wire logic config_complete_line_in,
  output logic      config_complete_line_out,
  output logic      config_complete_line_oe,
  input  wire logic status_line_in,
  output logic      status_line_out,
  output logic      status_line_oe,
  input  wire logic chain_enable_n,
  output logic      chain_enable_out_n,
  input  wire logic reconfig_request_n,
  output logic      serial_mem_command_out,
  output logic      serial_mem_select_n,
  output logic      user_mode
);

  // -------------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------------
  logic [1:0]        sync_done_reg;
  logic [1:0]        sync_stat_reg;
  logic [1:0]        sync_ce_reg;
  logic [1:0]        sync_cfg_reg;
  csc_pkg::csc_pins_s pins;

  // Two stages per pin; only stage 1 is read by logic
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync_done_reg <= '0;
      sync_stat_reg <= csc_pkg::CSC_SYNC_RESET;
      sync_ce_reg   <= csc_pkg::CSC_SYNC_RESET;
      sync_cfg_reg  <= csc_pkg::CSC_SYNC_RESET;
    end else begin
      sync_done_reg <= {sync_done_reg[0], config_complete_line_in};
      sync_stat_reg <= {sync_stat_reg[0], status_line_in};
      sync_ce_reg   <= {sync_ce_reg[0], chain_enable_n};
      sync_cfg_reg  <= {sync_cfg_reg[0], reconfig_request_n};
    end
  end

  assign pins.complete_line = sync_done_reg[1];
  assign pins.status_line   = sync_stat_reg[1];
  assign pins.chain_en_n    = sync_ce_reg[1];
  assign pins.reconfig_n    = sync_cfg_reg[1];

  // -------------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------------
  localparam int unsigned CSC_CNT_W = csc_pkg::CSC_CNT_W;
  csc_pkg::csc_state_e    state_reg, state_next;
  logic [csc_pkg::CSC_CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0]             bit_reg, bit_next;
  logic                   cmd_sent_reg, cmd_sent_next;
  logic                   reconf_prev_reg, reconf_prev_next;
  logic                   own_err;

  // Error seen during loading: a data word flagged bad
  assign own_err = data_word_valid && data_error;

  always_comb begin
    state_next       = state_reg;
    cnt_next         = cnt_reg;
    bit_next         = bit_reg;
    cmd_sent_next    = cmd_sent_reg;
    reconf_prev_next = pins.reconfig_n;
    unique case (state_reg)
      csc_pkg::CSC_IDLE: begin
        cmd_sent_next = 1'b0;
        bit_next      = '0;
        if (!pins.chain_en_n && pins.reconfig_n && pins.status_line) begin
          state_next = csc_pkg::CSC_LOAD;
        end
      end
      csc_pkg::CSC_LOAD: begin
        // Read command goes out one bit per clock in serial mode
        if (active_serial_mode && !cmd_sent_reg) begin
          bit_next = bit_reg + 3'h1;
          if (bit_reg == csc_pkg::CSC_BIT_LAST) begin
            cmd_sent_next = 1'b1;
          end
        end
        if (own_err || !pins.status_line) begin
          state_next = csc_pkg::CSC_ERROR;
        end else if (pins.chain_en_n) begin
          state_next = csc_pkg::CSC_IDLE;
        end else if (data_word_valid && data_last) begin
          state_next = csc_pkg::CSC_INIT;
          cnt_next   = '0;
        end
      end
      csc_pkg::CSC_INIT: begin
        if (!pins.status_line) begin
          state_next = csc_pkg::CSC_ERROR;
        end else if (pins.complete_line) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == CSC_CNT_W'(INIT_CYCLES - 1)) begin
            state_next = csc_pkg::CSC_USER;
          end
        end
      end
      csc_pkg::CSC_USER: begin
        // Completion and status lines are ignored here
        if (reconf_prev_reg && !pins.reconfig_n) begin
          state_next = csc_pkg::CSC_IDLE;
        end
      end
      csc_pkg::CSC_ERROR: begin
        if (!pins.reconfig_n) begin
          state_next = csc_pkg::CSC_IDLE;
        end
      end
      default: state_next = csc_pkg::CSC_IDLE;
    endcase
    if (!pins.reconfig_n && state_reg != csc_pkg::CSC_USER) begin
      state_next = csc_pkg::CSC_IDLE;
    end
  end

  // Sequencer state registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_reg       <= csc_pkg::CSC_IDLE;
      cnt_reg         <= '0;
      bit_reg         <= '0;
      cmd_sent_reg    <= 1'b0;
      reconf_prev_reg <= 1'b1;
    end else begin
      state_reg       <= state_next;
      cnt_reg         <= cnt_next;
      bit_reg         <= bit_next;
      cmd_sent_reg    <= cmd_sent_next;
      reconf_prev_reg <= reconf_prev_next;
    end
  end

  // -------------------------------------------------------------------------
  // Pad drivers
  // -------------------------------------------------------------------------
  csc_pkg::csc_pads_s pads_reg, pads_next;

  always_comb begin
    pads_next.complete_oe = (state_next == csc_pkg::CSC_IDLE) ||
                            (state_next == csc_pkg::CSC_LOAD) ||
                            (state_next == csc_pkg::CSC_ERROR);
    pads_next.status_oe   = (state_next == csc_pkg::CSC_ERROR);
    pads_next.chain_out_n = !((state_next == csc_pkg::CSC_INIT) ||
                              (state_next == csc_pkg::CSC_USER));
    pads_next.serial_mem_sel_n = !(active_serial_mode &&
                                   state_next == csc_pkg::CSC_LOAD);
    pads_next.serial_mem_command_out = (active_serial_mode &&
      state_next == csc_pkg::CSC_LOAD && !cmd_sent_next) ?
      csc_pkg::CSC_READ_OPCODE[csc_pkg::CSC_BIT_LAST - bit_next] : 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pads_reg.complete_oe            <= 1'b1;
      pads_reg.status_oe              <= 1'b0;
      pads_reg.chain_out_n            <= 1'b1;
      pads_reg.serial_mem_sel_n       <= 1'b1;
      pads_reg.serial_mem_command_out <= 1'b1;
    end else begin
      pads_reg <= pads_next;
    end
  end

  // Open-drain lines only ever drive low
  assign config_complete_line_out = 1'b0;
  assign config_complete_line_oe  = pads_reg.complete_oe;
  assign status_line_out          = 1'b0;
  assign status_line_oe           = pads_reg.status_oe;
  assign chain_enable_out_n       = pads_reg.chain_out_n;
  assign serial_mem_command_out   = pads_reg.serial_mem_command_out;
  assign serial_mem_select_n      = pads_reg.serial_mem_sel_n;
  assign user_mode                = (state_reg == csc_pkg::CSC_USER);

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  AST_DONE_LOW_IN_LOAD: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == csc_pkg::CSC_LOAD |-> config_complete_line_oe)
    else $error("completion line released during load");

  AST_DONE_RELEASE: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(state_reg == csc_pkg::CSC_INIT) |-> !config_complete_line_oe)
    else $error("completion line not released at init");

  AST_INIT_NEEDS_LINE: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == csc_pkg::CSC_INIT && !pins.complete_line && pins.status_line
    && pins.reconfig_n |=> state_reg == csc_pkg::CSC_INIT)
    else $error("init advanced while completion line low");

  AST_USER_HOLDS: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == csc_pkg::CSC_USER && !(reconf_prev_reg && !pins.reconfig_n)
    |=> state_reg == csc_pkg::CSC_USER)
    else $error("user mode left without reconfig request");

  AST_NO_LOAD_DISABLED: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == csc_pkg::CSC_IDLE && pins.chain_en_n
    |=> state_reg != csc_pkg::CSC_LOAD)
    else $error("load began while chain enable high");

  AST_CHAIN_OUT: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == csc_pkg::CSC_USER |-> !chain_enable_out_n)
    else $error("chain enable output high in user mode");

  AST_SEL_SERIAL_ONLY: assert property (@(posedge mclk) disable iff (!nrst)
    !active_serial_mode |=> serial_mem_select_n)
    else $error("serial memory selected outside serial mode");

  AST_ERR_DRIVE: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == csc_pkg::CSC_LOAD && own_err && pins.reconfig_n
    |=> status_line_oe)
    else $error("status line not pulled on error");

  AST_CMD_BIT: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(!serial_mem_select_n) |-> !serial_mem_command_out)
    else $error("read command first bit wrong");

endmodule // csc_handshake

// ===== csc_host_model.sv
// Far-side host model: pull-ups on the open-drain lines and host-driven pins
module csc_host_model (
  input  wire logic complete_oe,
  input  wire logic status_oe,
  input  wire logic hold_complete_low,
  input  wire logic hold_status_low,
  input  wire logic host_ce_n,
  input  wire logic host_reconfig_n,
  output logic      complete_line,
  output logic      status_line,
  output logic      chain_enable_n,
  output logic      reconfig_request_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups win unless some party pulls the line low
  assign complete_line = ~(complete_oe | hold_complete_low);
  assign status_line   = ~(status_oe | hold_status_low);
  // First device of the chain, enable driven directly by the host
  assign chain_enable_n = host_ce_n;
  // Reload asked for by a low pulse
  assign reconfig_request_n = host_reconfig_n;
endmodule // csc_host_model

// ===== testbench.sv
// Self-checking bench for the configuration handshake block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------------------------------
  // Signals and instances
  // -------------------------------------------------------------------
  logic       mclk = 1'h0, nrst = 1'h0, asm = 1'h0, vld = 1'h0, lst = 1'h0;
  logic       derr = 1'h0, hold_c = 1'h0, hold_s = 1'h0, ce_n = 1'h1, rcf_n = 1'h1;
  logic       c_line, s_line, ce_pin_n, rcf_pin_n, c_oe, s_oe, ceo_n, cmd, sel_n, user;
  logic       c_out, s_out;
  int         err_count = 0;
  int         cmp_count = 0;
  // Rows: serial, bad word, then expected complete_oe, chain_out_n, status_oe, user
  logic [5:0] rows [4] = '{6'h01, 6'h21, 6'h1E, 6'h3E};

  csc_handshake #(.INIT_CYCLES(2)) u_csc_handshake (
    .mclk(mclk), .nrst(nrst), .active_serial_mode(asm), .data_word_valid(vld),
    .data_last(lst), .data_error(derr), .config_complete_line_in(c_line),
    .config_complete_line_out(c_out), .config_complete_line_oe(c_oe),
    .status_line_in(s_line), .status_line_out(s_out), .status_line_oe(s_oe),
    .chain_enable_n(ce_pin_n), .chain_enable_out_n(ceo_n),
    .reconfig_request_n(rcf_pin_n), .serial_mem_command_out(cmd),
    .serial_mem_select_n(sel_n), .user_mode(user));

  csc_host_model u_csc_host_model (
    .complete_oe(c_oe), .status_oe(s_oe), .hold_complete_low(hold_c),
    .hold_status_low(hold_s), .host_ce_n(ce_n), .host_reconfig_n(rcf_n),
    .complete_line(c_line), .status_line(s_line), .chain_enable_n(ce_pin_n),
    .reconfig_request_n(rcf_pin_n));

  // Clock, 20 ns period
  always #10 mclk = ~mclk;
  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Reload pulse, back to idle with the chip enable high
  task automatic restart();
    ce_n = 1'h1;
    rcf_n = 1'h0;
    cyc(4);
    rcf_n = 1'h1;
    cyc(4);
  endtask
  // Enable loading; in serial mode follow the read opcode stream
  task automatic load(input logic serial);
    asm = serial;
    ce_n = 1'h0;
    if (serial) begin
      for (int i = 0; i < 10 && sel_n !== 1'h0; i++) cyc(1);
      for (int i = 7; i >= 0; i--) begin
        chk(sel_n, 1'h0);
        chk(cmd, csc_pkg::CSC_READ_OPCODE[i]);
        cyc(1);
      end
      chk(cmd, 1'h1);
    end else begin
      cyc(4);
    end
  endtask
  // One data word, final or bad
  task automatic strobe(input logic bad);
    vld = 1'h1;
    lst = ~bad;
    derr = bad;
    cyc(1);
    vld = 1'h0;
    lst = 1'h0;
    derr = 1'h0;
    cyc(1);
  endtask
  task automatic settle();
    for (int i = 0; i < 30 && user !== 1'h1 && s_oe !== 1'h1; i++) cyc(1);
  endtask
  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    cyc(16);
    nrst = 1'h1;
    cyc(1);
    chk(c_oe, 1'h1);
    chk(ceo_n, 1'h1);
    chk(sel_n, 1'h1);
    chk(user, 1'h0);
    chk(s_oe, 1'h0);
    foreach (rows[r]) begin
      load(rows[r][5]);
      chk(c_oe, 1'h1);
      strobe(rows[r][4]);
      settle();
      chk(c_oe, rows[r][3]);
      chk(ceo_n, rows[r][2]);
      chk(s_oe, rows[r][1]);
      chk(user, rows[r][0]);
      chk(sel_n, 1'h1);
      chk(c_out, 1'h0);
      chk(s_out, 1'h0);
      restart();
    end
    // User mode ignores outside lows on both lines
    load(1'h0);
    strobe(1'h0);
    settle();
    hold_c = 1'h1;
    hold_s = 1'h1;
    cyc(10);
    chk(user, 1'h1);
    chk(s_oe, 1'h0);
    chk(ceo_n, 1'h0);
    hold_c = 1'h0;
    hold_s = 1'h0;
    restart();
    // Init waits while the completion line is held low outside
    load(1'h0);
    hold_c = 1'h1;
    strobe(1'h0);
    cyc(12);
    chk(user, 1'h0);
    chk(c_oe, 1'h0);
    hold_c = 1'h0;
    settle();
    chk(user, 1'h1);
    restart();
    // Outside error low while loading, seen after the synchroniser
    load(1'h0);
    hold_s = 1'h1;
    cyc(2);
    chk(s_oe, 1'h0);
    cyc(2);
    chk(s_oe, 1'h1);
    hold_s = 1'h0;
    restart();
    // Strobes ignored with the chip enable high, also after it is lost
    strobe(1'h0);
    cyc(6);
    chk(c_oe, 1'h1);
    ce_n = 1'h0;
    cyc(4);
    ce_n = 1'h1;
    cyc(4);
    strobe(1'h0);
    cyc(6);
    chk(c_oe, 1'h1);
    chk(ceo_n, 1'h1);
    // Reset in user mode, then a fresh load once the synchronisers refill
    load(1'h0);
    strobe(1'h0);
    settle();
    nrst = 1'h0;
    cyc(2);
    chk(user, 1'h0);
    chk(c_oe, 1'h1);
    chk(ceo_n, 1'h1);
    chk(s_oe, 1'h0);
    nrst = 1'h1;
    cyc(1);
    chk(c_oe, 1'h1);
    chk(sel_n, 1'h1);
    cyc(3);
    strobe(1'h0);
    settle();
    chk(user, 1'h1);
    chk(ceo_n, 1'h0);
    wrap_up();
  end
  // Watchdog
  initial begin
    cyc(2000);
    err_count++;
    wrap_up();
  end
endmodule // testbench
